//--- hw/wave_seq_pkg.sv
// What this block does
// - trigger starts playback at slot offset 0x03
// - after waveform done, advance to next slot
// - zero identifier ends sequence immediately
// - slots are 8-bit read/write, reset zero
//
// Purpose: constants for the waveform sequence slot bank
// Assumes: one register clock, synchronous active-low reset
// Notes:   slot offsets are byte register addresses of the serial port
package wave_seq_pkg;
  localparam int          SLOT_COUNT  = 8;              // slots per sequence
  localparam int          SLOT_WIDTH  = 8;              // identifier width
  localparam int          ADDR_WIDTH  = 8;              // register address width
  localparam int          IDX_WIDTH   = 3;              // slot index width
  localparam logic [7:0]  SLOT_BASE   = 8'h03;          // first slot offset
  localparam logic [7:0]  SLOT_RESET  = 8'h00;          // slot reset value
  localparam logic [7:0]  ID_END      = 8'h00;          // terminating identifier
  localparam logic [7:0]  OFS_SLOT_FOUR = 8'h07;        // sequence_slot_four
  localparam logic [7:0]  OFS_SLOT_FIVE = 8'h08;        // sequence_slot_five
  localparam logic [7:0]  OFS_SLOT_SIX  = 8'h09;        // sequence_slot_six
  localparam logic [2:0]  IDX_FIRST   = 3'h0;           // first slot index
  localparam logic [2:0]  IDX_LAST    = 3'h7;           // last slot index
  localparam logic [2:0]  IDX_STEP    = 3'h1;           // slot increment

  // sequencer states
  typedef enum logic [1:0] {
    ST_IDLE  = 2'b00,  // waiting for trigger
    ST_FETCH = 2'b01,  // reading current slot
    ST_PLAY  = 2'b10   // waveform playing
  } seq_state_t;
endpackage

//--- hw/slot_bank.sv
// Purpose: byte-wide sequence slot storage with read mux
// Assumes: write strobe and read index from the register port, same clock
// Notes:   second read port serves the sequencer fetch
`timescale 1ns/10ps
module slot_bank #(
  parameter int NUM = wave_seq_pkg::SLOT_COUNT  // number of slots
) (
  input  wire logic                                i_clk_sys,  // system clock
  input  wire logic                                i_nrst,     // sync reset, active low
  input  wire logic                                i_wr,       // write strobe
  input  wire logic [wave_seq_pkg::IDX_WIDTH-1:0]  i_wr_idx,   // write slot index
  input  wire logic [wave_seq_pkg::SLOT_WIDTH-1:0] i_wr_data,  // write data
  input  wire logic [wave_seq_pkg::IDX_WIDTH-1:0]  i_rd_idx,   // host read index
  input  wire logic [wave_seq_pkg::IDX_WIDTH-1:0]  i_seq_idx,  // sequencer read index
  output logic      [wave_seq_pkg::SLOT_WIDTH-1:0] o_rd_data,  // host read data
  output logic      [wave_seq_pkg::SLOT_WIDTH-1:0] o_seq_data  // sequencer read data
);
  logic [wave_seq_pkg::SLOT_WIDTH-1:0] slot_r [NUM];  // slot storage

  ////////////////////////////////////////////////////////////////////////////
  // one register per slot, cleared on reset
  for (genvar g = 0; g < NUM; g++) begin : g_slot
    always_ff @(posedge i_clk_sys) begin
      if (!i_nrst) begin
        slot_r[g] <= wave_seq_pkg::SLOT_RESET;
      end else if (i_wr && (i_wr_idx == wave_seq_pkg::IDX_WIDTH'(g))) begin
        slot_r[g] <= i_wr_data;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // read ports are plain muxes
  assign o_rd_data  = slot_r[i_rd_idx];
  assign o_seq_data = slot_r[i_seq_idx];
endmodule  // slot_bank

//--- hw/wave_seq_slots.sv
// Purpose: waveform sequence slots and the slot-walking playback sequencer
// Assumes: register port gives one-cycle write/read strobes on i_clk_sys;
//          the waveform player acknowledges each waveform with a done pulse
// Notes:   read data registered, valid one cycle after the read strobe;
//          a trigger that arrives while a sequence runs is dropped, not queued;
//          identifiers are sampled at fetch, so host writes to later slots
//          still take effect in the running sequence
`timescale 1ns/10ps
module wave_seq_slots (
  input  wire logic       i_clk_sys,    // system clock, 250 MHz
  input  wire logic       i_nrst,       // sync reset, active low
  input  wire logic       i_reg_wr,     // register write strobe
  input  wire logic       i_reg_rd,     // register read strobe
  input  wire logic [7:0] i_reg_addr,   // register address
  input  wire logic [7:0] i_reg_wdata,  // register write data
  output logic      [7:0] o_reg_rdata,  // register read data
  output logic            o_reg_hit,    // address maps to a slot (comb)
  input  wire logic       i_go,         // playback trigger pulse
  output logic            o_busy,       // sequence in progress
  output logic            o_play,       // start-play pulse to the player
  output logic      [7:0] o_wave_id,    // waveform index to play
  input  wire logic       i_play_done   // player finished pulse
);
  localparam int NUM = wave_seq_pkg::SLOT_COUNT;  // slot count

  wave_seq_pkg::seq_state_t state_r;    // sequencer state
  wave_seq_pkg::seq_state_t state_nxt;  // next state
  logic [2:0] idx_r;                    // current slot index
  logic [7:0] rel_addr;                 // address relative to first slot
  logic [7:0] host_data;                // host read mux
  logic [7:0] seq_data;                 // slot under the sequencer
  logic       wr_hit;                   // qualified slot write

  ////////////////////////////////////////////////////////////////////////////
  // address decode: slots occupy 0x03..0x0a contiguously
  assign rel_addr  = i_reg_addr - wave_seq_pkg::SLOT_BASE;
  assign o_reg_hit = (i_reg_addr >= wave_seq_pkg::SLOT_BASE) &&
                     (rel_addr < 8'(NUM));
  // writes outside the slot range are dropped here
  assign wr_hit    = i_reg_wr && o_reg_hit;

  slot_bank #(.NUM(NUM)) u_bank (
    .i_clk_sys  (i_clk_sys),
    .i_nrst     (i_nrst),
    .i_wr       (wr_hit),
    .i_wr_idx   (rel_addr[2:0]),
    .i_wr_data  (i_reg_wdata),
    .i_rd_idx   (rel_addr[2:0]),
    .i_seq_idx  (idx_r),
    .o_rd_data  (host_data),
    .o_seq_data (seq_data)
  );

  ////////////////////////////////////////////////////////////////////////////
  // registered read data; unmapped addresses read zero
  always_ff @(posedge i_clk_sys) begin
    if (!i_nrst) begin
      o_reg_rdata <= wave_seq_pkg::SLOT_RESET;
    end else if (i_reg_rd) begin
      // held between strobes so a slow host can pick it up late
      o_reg_rdata <= o_reg_hit ? host_data : wave_seq_pkg::SLOT_RESET;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // sequencer next state: idle, then fetch and play each slot in turn
  always_comb begin
    state_nxt = state_r;  // hold by default
    unique case (state_r)
      wave_seq_pkg::ST_IDLE: begin
        // only idle listens to the trigger, so a retrigger is ignored
        if (i_go) begin
          state_nxt = wave_seq_pkg::ST_FETCH;
        end
      end
      wave_seq_pkg::ST_FETCH: begin
        // zero id ends at once, nothing played
        if (seq_data == wave_seq_pkg::ID_END) begin
          state_nxt = wave_seq_pkg::ST_IDLE;
        end else begin
          state_nxt = wave_seq_pkg::ST_PLAY;
        end
      end
      wave_seq_pkg::ST_PLAY: begin
        // wait for the player; a done pulse in any other state is ignored
        if (i_play_done) begin
          // last slot played: stop, else fetch next
          if (idx_r == wave_seq_pkg::IDX_LAST) begin
            state_nxt = wave_seq_pkg::ST_IDLE;
          end else begin
            state_nxt = wave_seq_pkg::ST_FETCH;
          end
        end
      end
      default: begin
        state_nxt = wave_seq_pkg::ST_IDLE;  // 2'b11 is illegal, recover to idle
      end
    endcase
  end

  // state register
  always_ff @(posedge i_clk_sys) begin
    if (!i_nrst) state_r <= wave_seq_pkg::ST_IDLE;
    else         state_r <= state_nxt;
  end

  // slot pointer: reset to first slot on trigger, step on done
  always_ff @(posedge i_clk_sys) begin
    if (!i_nrst) begin
      idx_r <= wave_seq_pkg::IDX_FIRST;
    end else if (state_r == wave_seq_pkg::ST_IDLE && i_go) begin
      idx_r <= wave_seq_pkg::IDX_FIRST;
    end else if (state_r == wave_seq_pkg::ST_PLAY && i_play_done &&
                 idx_r != wave_seq_pkg::IDX_LAST) begin
      // held at the last slot so the pointer never wraps back to slot 0
      idx_r <= idx_r + wave_seq_pkg::IDX_STEP;
    end
  end

  // play request: id latched at fetch so host writes mid-play are harmless
  always_ff @(posedge i_clk_sys) begin
    if (!i_nrst) begin
      o_play    <= 1'b0;
      o_wave_id <= wave_seq_pkg::ID_END;
    end else begin
      // pulse only for a nonzero id; a zero id plays nothing
      o_play <= (state_r == wave_seq_pkg::ST_FETCH) &&
                (seq_data != wave_seq_pkg::ID_END);
      // id held until the next fetch, the player may read it late
      if (state_r == wave_seq_pkg::ST_FETCH) begin
        o_wave_id <= seq_data;
      end
    end
  end

  // busy straight from the state register, so no extra cycle of lag
  assign o_busy = (state_r != wave_seq_pkg::ST_IDLE);

  ////////////////////////////////////////////////////////////////////////////
  // checks: all on the system clock, off while reset is held
  default clocking cb @(posedge i_clk_sys); endclocking
  default disable iff (!i_nrst);

  // trigger in idle starts at the first slot
  chk_go_first_slot: assert property (
    (state_r == wave_seq_pkg::ST_IDLE && i_go)
    |=> idx_r == wave_seq_pkg::IDX_FIRST && state_r == wave_seq_pkg::ST_FETCH)
    else $error("trigger did not fetch first slot");

  // without a trigger the sequencer stays idle, stray done pulses too
  chk_idle_stay: assert property (
    (state_r == wave_seq_pkg::ST_IDLE && !i_go) |=> !o_busy)
    else $error("sequencer left idle without a trigger");

  // done moves the pointer one slot on and fetches it
  chk_done_advance: assert property (
    (state_r == wave_seq_pkg::ST_PLAY && i_play_done && idx_r != wave_seq_pkg::IDX_LAST)
    |=> idx_r == $past(idx_r) + wave_seq_pkg::IDX_STEP &&
        state_r == wave_seq_pkg::ST_FETCH)
    else $error("slot pointer did not advance");

  // the pointer only moves on a done pulse once a sequence runs, so a
  // retrigger while busy cannot restart it
  chk_ptr_hold: assert property (
    (state_r != wave_seq_pkg::ST_IDLE && !i_play_done) |=> $stable(idx_r))
    else $error("slot pointer moved without a done pulse");

  // a zero id ends the sequence with no play pulse
  chk_zero_ends: assert property (
    (state_r == wave_seq_pkg::ST_FETCH && seq_data == wave_seq_pkg::ID_END)
    |=> state_r == wave_seq_pkg::ST_IDLE && !o_play)
    else $error("zero id did not end sequence");

  // done on the last slot ends the sequence
  chk_last_ends: assert property (
    (state_r == wave_seq_pkg::ST_PLAY && i_play_done && idx_r == wave_seq_pkg::IDX_LAST)
    |=> !o_busy)
    else $error("sequence ran past last slot");

  // a slot written and read back in the next cycle returns the new byte
  chk_slot_write: assert property (
    (wr_hit && i_reg_addr == wave_seq_pkg::OFS_SLOT_FIVE) ##1
    (i_reg_rd && i_reg_addr == wave_seq_pkg::OFS_SLOT_FIVE && !i_reg_wr)
    |=> o_reg_rdata == $past(i_reg_wdata, 2))
    else $error("slot did not hold written byte");

  // unmapped reads return zero
  chk_unmapped_zero: assert property (
    (i_reg_rd && !o_reg_hit) |=> o_reg_rdata == wave_seq_pkg::SLOT_RESET)
    else $error("unmapped read not zero");

  // the hit flag covers exactly the slot range
  chk_hit_range: assert property (
    o_reg_hit == (i_reg_addr >= wave_seq_pkg::SLOT_BASE &&
                  i_reg_addr <= wave_seq_pkg::SLOT_BASE + 8'(NUM - 1)))
    else $error("slot address decode wrong");

  // read data holds between read strobes
  chk_rdata_hold: assert property (
    !i_reg_rd |=> $stable(o_reg_rdata))
    else $error("read data changed without a read");

  // the player gets a pulse and the fetched id after a nonzero fetch
  chk_play_id: assert property (
    (state_r == wave_seq_pkg::ST_FETCH && seq_data != wave_seq_pkg::ID_END)
    |=> o_play && o_wave_id == $past(seq_data) ##1 !o_play)
    else $error("nonzero id not sent to player");

  // a play pulse only ever follows a fetch
  chk_play_after_fetch: assert property (
    o_play |-> $past(state_r) == wave_seq_pkg::ST_FETCH)
    else $error("play pulse without a fetch");

  // the id stays put while its waveform plays
  chk_id_hold: assert property (
    (state_r == wave_seq_pkg::ST_PLAY) |=> $stable(o_wave_id))
    else $error("waveform id changed during play");

  // play pulses only inside a running sequence
  chk_play_busy: assert property (
    o_play |-> o_busy)
    else $error("play pulse outside a sequence");

  // main scenarios: full run, early stop, trigger, retrigger, back-to-back access
  cov_full_run: cover property (
    state_r == wave_seq_pkg::ST_PLAY && i_play_done && idx_r == wave_seq_pkg::IDX_LAST);
  cov_zero_stop: cover property (
    state_r == wave_seq_pkg::ST_FETCH && seq_data == wave_seq_pkg::ID_END &&
    idx_r != wave_seq_pkg::IDX_FIRST);
  cov_go: cover property (state_r == wave_seq_pkg::ST_IDLE && i_go);
  cov_retrigger: cover property (state_r == wave_seq_pkg::ST_PLAY && i_go);
  cov_wr_then_rd: cover property (wr_hit ##1 (i_reg_rd && o_reg_hit));
endmodule  // wave_seq_slots

//--- testbench/test_wave_seq_slots.sv
// Purpose: self-checking bench for the waveform sequence slot bank and its sequencer
// Assumes: one clock, synchronous active-low reset, inputs driven 1 ns after the rising edge
// Notes:   expected sequences come from a shadow copy of the slots held by the bench
`timescale 1ns/10ps
module test_wave_seq_slots;
  logic       i_clk_sys, i_nrst, i_reg_wr, i_reg_rd, i_go, i_play_done; // dut inputs
  logic [7:0] i_reg_addr, i_reg_wdata;                                // register bus inputs
  logic [7:0] o_reg_rdata, o_wave_id;                                 // dut byte outputs
  logic       o_reg_hit, o_busy, o_play;                              // dut flag outputs
  logic [7:0] lfsr_r;                                                 // random source
  logic [7:0] exp_slot [8];                                           // shadow of the slots
  int         num_errors, n_tests, cyc;                               // counters

  wave_seq_slots dut (.i_clk_sys(i_clk_sys), .i_nrst(i_nrst), .i_reg_wr(i_reg_wr),
    .i_reg_rd(i_reg_rd), .i_reg_addr(i_reg_addr), .i_reg_wdata(i_reg_wdata),
    .o_reg_rdata(o_reg_rdata), .o_reg_hit(o_reg_hit), .i_go(i_go), .o_busy(o_busy),
    .o_play(o_play), .o_wave_id(o_wave_id), .i_play_done(i_play_done));

  ////////////////////////////////////////////////////////////////////////////////
  // clock, 4 ns period, and a hang guard well above the expected run length
  initial begin
    i_clk_sys = 1'b0;
    forever #2 i_clk_sys = ~i_clk_sys;
  end
  always @(posedge i_clk_sys) begin
    cyc++;
    if (cyc == 20000) begin
      num_errors++;
      end_sim();
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // helpers: random bytes, compare, register access, closing report
  function automatic logic [7:0] lfsr_next(input logic [7:0] v);
    return {v[6:0], v[7] ^ v[5] ^ v[4] ^ v[3]};  // maximal 8-bit taps, never locks at zero
  endfunction
  task automatic check(input string what, input logic [7:0] exp, input logic [7:0] got);
    n_tests++;
    if (got !== exp) begin  // case inequality so an unknown never matches
      num_errors++;
      $display("CHECK FAILED %s expected %h seen %h", what, exp, got);
    end
  endtask
  task automatic wr(input logic [7:0] addr, input logic [7:0] data);
    @(posedge i_clk_sys) #1 {i_reg_wr, i_reg_addr, i_reg_wdata} = {1'b1, addr, data};
    if (addr >= 8'h03 && addr <= 8'h0a) exp_slot[addr - 8'h03] = data;  // mapped only
    @(posedge i_clk_sys) #1 i_reg_wr = 1'b0;
  endtask
  // write, then read the same address in the very next cycle
  task automatic wr_rd(input logic [7:0] addr, input logic [7:0] data);
    logic [7:0] exp;
    exp = (addr >= 8'h03 && addr <= 8'h0a) ? data : 8'h00;
    @(posedge i_clk_sys) #1 {i_reg_wr, i_reg_addr, i_reg_wdata} = {1'b1, addr, data};
    if (addr >= 8'h03 && addr <= 8'h0a) exp_slot[addr - 8'h03] = data;
    @(posedge i_clk_sys) #1 {i_reg_wr, i_reg_rd} = 2'b01;  // read follows at once
    #1 check("reg_hit_b2b", {7'h00, addr >= 8'h03 && addr <= 8'h0a}, {7'h00, o_reg_hit});
    @(posedge i_clk_sys) #1 i_reg_rd = 1'b0;
    check("reg_rdata_b2b", exp, o_reg_rdata);
  endtask
  task automatic rd(input logic [7:0] addr);
    logic [7:0] exp;
    exp = (addr >= 8'h03 && addr <= 8'h0a) ? exp_slot[addr - 8'h03] : 8'h00;
    @(posedge i_clk_sys) #1 {i_reg_rd, i_reg_addr} = {1'b1, addr};
    #1 check("reg_hit", {7'h00, addr >= 8'h03 && addr <= 8'h0a}, {7'h00, o_reg_hit});
    @(posedge i_clk_sys) #1 i_reg_rd = 1'b0;
    check("reg_rdata", exp, o_reg_rdata);
  endtask
  task automatic end_sim();
    $display("tests %0d errors %0d", n_tests, num_errors);
    if (num_errors == 0 && n_tests > 0)
      $display("TB: PASS");
    else
      $display("TB: FAIL");
    $finish;
  endtask

  ////////////////////////////////////////////////////////////////////////////////
  // one playback: trigger, retrigger while busy, answer each play with done gap+2 cycles after the pulse
  task automatic run_seq(input int gap);
    logic [7:0] ids [$];
    int         plays;
    plays = 0;
    for (int k = 0; k < 8 && exp_slot[k] != 8'h00; k++) ids.push_back(exp_slot[k]);
    @(posedge i_clk_sys) #1 i_go = 1'b1;
    @(posedge i_clk_sys) #1 i_go = 1'b0;
    check("busy_after_go", 8'h01, {7'h00, o_busy});
    for (int t = 0; t < 400 && o_busy === 1'b1; t++) begin
      @(posedge i_clk_sys) #1;
      if (o_play === 1'b1) begin
        check("wave_id", (plays < ids.size()) ? ids[plays] : 8'h00, o_wave_id);
        plays++;
        @(posedge i_clk_sys) #1 i_go = 1'b1;  // must be ignored, no restart
        @(posedge i_clk_sys) #1 i_go = 1'b0;
        repeat (gap) @(posedge i_clk_sys);
        #1 i_play_done = 1'b1;
        @(posedge i_clk_sys) #1 i_play_done = 1'b0;
      end
    end
    check("play_count", 8'(ids.size()), 8'(plays));
    check("busy_end", 8'h00, {7'h00, o_busy});
  endtask

  ////////////////////////////////////////////////////////////////////////////////
  // main sequence
  initial begin
    {i_nrst, i_reg_wr, i_reg_rd, i_go, i_play_done, i_reg_addr, i_reg_wdata} = '0;
    lfsr_r = 8'h56;  // seed 86
    num_errors = 0;
    n_tests = 0;
    cyc = 0;
    for (int k = 0; k < 8; k++) exp_slot[k] = 8'h00;
    repeat (8) @(posedge i_clk_sys);
    #1 i_nrst = 1'b1;
    check("wave_id_rst", 8'h00, o_wave_id);
    @(posedge i_clk_sys) #1 i_play_done = 1'b1;  // stray done while idle
    @(posedge i_clk_sys) #1 i_play_done = 1'b0;
    check("busy_stray_done", 8'h00, {7'h00, o_busy});
    for (int a = 2; a < 12; a++) rd(8'(a));
    wr(8'h0b, 8'hff);
    rd(8'h0b);
    run_seq(1);
    for (int z = 8; z >= 1; z -= 3) begin
      for (int k = 0; k < 8; k++) begin
        lfsr_r = lfsr_next(lfsr_r);
        wr_rd(8'(k + 3), lfsr_r | 8'h01);
        rd(8'(k + 3));
      end
      if (z < 8) wr(8'(z + 3), 8'h00);
      run_seq(z);
    end
    end_sim();
  end
endmodule // test_wave_seq_slots
